// ==== pkg/pulse_cmd_pkg.sv ====
// Constants shared by the pulse counter command unit and its helpers.
// Assumes a single 100 MHz clock domain; no bus, all ports are plain.
package pulse_cmd_pkg;

  // ***************************************************
  // Commands and states
  // ***************************************************
  typedef enum logic [7:0] {
    CMD_RESERVED = 8'h00,
    CMD_RUN      = 8'h01,
    CMD_STOP     = 8'h02,
    CMD_LOAD     = 8'h03,
    CMD_PRESET   = 8'h04
  } cmd_e;

  typedef enum logic [0:0] {
    RUN_IDLE   = 1'b0,
    RUN_ACTIVE = 1'b1
  } run_e;

  // ***************************************************
  // Execution status codes
  // ***************************************************
  localparam logic [15:0] STS_DISABLED = 16'h0000;
  localparam logic [15:0] STS_OK       = 16'h0001;
  localparam logic [15:0] STS_BAD_CMD  = 16'h0002;
  localparam logic [15:0] STS_BAD_ID   = 16'h0003;
  localparam logic [15:0] STS_CFG_ERR  = 16'h0004;

  // ***************************************************
  // Identity, flags and reset values
  // ***************************************************
  // Counter identifier served by this unit (arbitrary)
  localparam logic [7:0] OWN_COUNTER_ID = 8'h00;

  localparam int FLAG_W = 5;
  localparam int F_DONE = 0;
  localparam int F_UPPER = 1;
  localparam int F_LOWER = 2;
  localparam int F_OVER = 3;
  localparam int F_UNDER = 4;

  localparam logic [FLAG_W-1:0] FLAGS_CLEAR = 5'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] ACC_STEP = 32'h0000_0001;

endpackage : pulse_cmd_pkg

// ==== src/cfg_slot.sv ====
// One configuration word held by the counter hardware.
// Assumes load comes from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module cfg_slot
  import pulse_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [31:0] din,
  output logic [31:0] q
);

  logic [31:0] q_r;
  logic [31:0] q_nxt;

  always_comb begin
    q_nxt = load ? din : q_r;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q_r <= WORD_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule // cfg_slot
`default_nettype wire

// ==== src/status_override.sv ====
// Status override call: decides whether event flags are rewritten.
// Assumes inputs come from logic on sys_clk, one call per clock.
`timescale 1ns/1ps
`default_nettype none
module status_override
  import pulse_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic set_enable,
  input wire logic [7:0] set_counter_id,
  input wire logic [FLAG_W-1:0] set_flags,
  output logic write_en,
  output logic [FLAG_W-1:0] write_flags,
  output logic [15:0] set_sts
);

  logic write_en_r;
  logic write_en_nxt;
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] flags_nxt;
  logic [15:0] sts_r;
  logic [15:0] sts_nxt;

  // Never yields the bad-command or config-error codes
  always_comb begin
    write_en_nxt = 1'b0;
    flags_nxt = flags_r;
    if (!set_enable) begin
      sts_nxt = STS_DISABLED;
    end else if (set_counter_id != OWN_COUNTER_ID) begin
      sts_nxt = STS_BAD_ID;
    end else begin
      sts_nxt = STS_OK;
      write_en_nxt = 1'b1;
      flags_nxt = set_flags;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      write_en_r <= 1'b0;
      flags_r <= FLAGS_CLEAR;
      sts_r <= STS_DISABLED;
    end else begin
      write_en_r <= write_en_nxt;
      flags_r <= flags_nxt;
      sts_r <= sts_nxt;
    end
  end

  assign write_en = write_en_r;
  assign write_flags = flags_r;
  assign set_sts = sts_r;

endmodule // status_override
`default_nettype wire

// ==== src/pulse_counter_command_unit.sv ====
// Command unit and live state of one fast_pulse_counter.
// Assumes one call per clock from same-domain logic; pulse pins are async.
//
// Contract
// - Enable false: no counter operation, status info not refreshed.
// - Command 1 starts an idle counter; if running it only refreshes status.
// - Command 2 stops a running counter.
// - Dropping enable never stops a running counter; only stop does.
// - Command 3 loads six config words, keeps counting, leaves accumulator.
// - Held load command reloads on every execution.
// - Command 4 sets accumulator and status accumulator to preload value, clears event flags.
// - Command 4 keeps counting; pulses during rewrite may be lost.
// - Config accumulator field mirrors the live accumulator.
// - Status codes: 0 off, 1 ok, 2 bad command, 3 bad id, 4 config error.
// - Command is 8 bits, status 16 bits, command 0 reserved.
// - Enabled override with own id sets or clears the five event flags; else nothing.
// - Override status never reports bad command or config error.
// - Upper setpoint above overflow limit gives a config error.
`timescale 1ns/1ps
`default_nettype none
module pulse_counter_command_unit
  import pulse_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cmd_enable,
  input wire logic [7:0] counter_id,
  input wire logic [7:0] counter_command,
  input wire logic signed [31:0] upper_setpoint_cfg,
  input wire logic signed [31:0] lower_setpoint_cfg,
  input wire logic [31:0] upper_output_pattern,
  input wire logic [31:0] lower_output_pattern,
  input wire logic signed [31:0] overflow_limit,
  input wire logic signed [31:0] underflow_limit,
  input wire logic [31:0] preload_count_value,
  input wire logic count_pulse,
  input wire logic count_down,
  input wire logic set_enable,
  input wire logic [7:0] set_counter_id,
  input wire logic single_run_done,
  input wire logic upper_setpoint_hit,
  input wire logic lower_setpoint_hit,
  input wire logic overflow_seen,
  input wire logic underflow_seen,
  output logic [15:0] exec_sts,
  output logic [15:0] set_sts,
  output logic counting,
  output logic [31:0] cfg_acc_mirror,
  output logic [31:0] status_acc,
  output logic [31:0] status_upper,
  output logic [31:0] status_lower,
  output logic [31:0] status_upper_out,
  output logic [31:0] status_lower_out,
  output logic [FLAG_W-1:0] status_flags
);

  // ***************************************************
  // Command decode
  // ***************************************************
  logic id_ok;
  logic cmd_known;
  logic cfg_bad;
  logic go;
  logic do_run;
  logic do_stop;
  logic do_load;
  logic do_preset;
  always_comb begin
    id_ok = (counter_id == OWN_COUNTER_ID);
    cmd_known = (counter_command >= CMD_RUN) &&
                (counter_command <= CMD_PRESET);
    // Reject lower below underflow as well as upper above overflow
    cfg_bad = (upper_setpoint_cfg > overflow_limit) ||
              (lower_setpoint_cfg < underflow_limit);
    go = cmd_enable && id_ok && cmd_known;
    do_run = go && (counter_command == CMD_RUN);
    do_stop = go && (counter_command == CMD_STOP);
    do_load = go && (counter_command == CMD_LOAD) && !cfg_bad;
    do_preset = go && (counter_command == CMD_PRESET);
  end

  // ***************************************************
  // Configuration words in the counter hardware
  // ***************************************************
  logic [31:0] hw_upper;
  logic [31:0] hw_lower;
  logic [31:0] hw_upper_out;
  logic [31:0] hw_lower_out;
  logic [31:0] hw_over;
  logic [31:0] hw_under;
  // All six words load together, accumulator untouched
  cfg_slot u_upper (.sys_clk(sys_clk), .nrst(nrst), .load(do_load),
    .din(upper_setpoint_cfg), .q(hw_upper));
  cfg_slot u_lower (.sys_clk(sys_clk), .nrst(nrst), .load(do_load),
    .din(lower_setpoint_cfg), .q(hw_lower));
  cfg_slot u_upper_out (.sys_clk(sys_clk), .nrst(nrst), .load(do_load),
    .din(upper_output_pattern), .q(hw_upper_out));
  cfg_slot u_lower_out (.sys_clk(sys_clk), .nrst(nrst), .load(do_load),
    .din(lower_output_pattern), .q(hw_lower_out));
  cfg_slot u_over (.sys_clk(sys_clk), .nrst(nrst), .load(do_load),
    .din(overflow_limit), .q(hw_over));
  cfg_slot u_under (.sys_clk(sys_clk), .nrst(nrst), .load(do_load),
    .din(underflow_limit), .q(hw_under));

  // ***************************************************
  // Status override call
  // ***************************************************
  logic ovr_we;
  logic [FLAG_W-1:0] ovr_flags;
  status_override u_override (
    .sys_clk(sys_clk), .nrst(nrst), .set_enable(set_enable),
    .set_counter_id(set_counter_id),
    .set_flags({underflow_seen, overflow_seen, lower_setpoint_hit,
                upper_setpoint_hit, single_run_done}),
    .write_en(ovr_we), .write_flags(ovr_flags), .set_sts(set_sts)
  );

  // ***************************************************
  // Pulse pin synchronisers
  // ***************************************************
  logic p_s1_r;
  logic p_s2_r;
  logic p_s3_r;
  logic d_s1_r;
  logic d_s2_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      p_s1_r <= 1'b0;
      p_s2_r <= 1'b0;
      p_s3_r <= 1'b0;
      d_s1_r <= 1'b0;
      d_s2_r <= 1'b0;
    end else begin
      p_s1_r <= count_pulse;
      p_s2_r <= p_s1_r;
      p_s3_r <= p_s2_r;
      d_s1_r <= count_down;
      d_s2_r <= d_s1_r;
    end
  end

  // ***************************************************
  // Run state, accumulator and event flags
  // ***************************************************
  run_e run_r;
  run_e run_nxt;
  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] flags_nxt;
  logic [FLAG_W-1:0] events;
  logic step;
  always_comb begin
    run_nxt = run_r;
    case (run_r)
      RUN_IDLE: begin
        if (do_run) begin
          run_nxt = RUN_ACTIVE;
        end
      end
      RUN_ACTIVE: begin
        // Enable low keeps counting
        if (do_stop) begin
          run_nxt = RUN_IDLE;
        end
      end
      default: run_nxt = RUN_IDLE;
    endcase
  end

  always_comb begin
    step = (run_r == RUN_ACTIVE) && p_s2_r && !p_s3_r;
    events = FLAGS_CLEAR;
    acc_nxt = acc_r;
    if (do_preset) begin
      // Edge in this cycle is dropped; run state untouched
      acc_nxt = preload_count_value;
    end else if (step && !d_s2_r) begin
      if (acc_r == hw_over) begin
        events[F_OVER] = 1'b1;
        acc_nxt = WORD_RESET;
      end else begin
        acc_nxt = acc_r + ACC_STEP;
        events[F_UPPER] = (acc_nxt == hw_upper);
        events[F_DONE] = events[F_UPPER];
      end
    end else if (step) begin
      if (acc_r == hw_under) begin
        events[F_UNDER] = 1'b1;
        acc_nxt = WORD_RESET;
      end else begin
        acc_nxt = acc_r - ACC_STEP;
        events[F_LOWER] = (acc_nxt == hw_lower);
      end
    end
    // An event in the cycle of an override clear still lands
    if (do_preset) begin
      flags_nxt = FLAGS_CLEAR;
    end else if (ovr_we) begin
      flags_nxt = ovr_flags | events;
    end else begin
      flags_nxt = flags_r | events;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_r <= RUN_IDLE;
      acc_r <= WORD_RESET;
      flags_r <= FLAGS_CLEAR;
    end else begin
      run_r <= run_nxt;
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
    end
  end

  // ***************************************************
  // Status info snapshot and execution status
  // ***************************************************
  logic [31:0] s_acc_r;
  logic [31:0] s_acc_nxt;
  logic [FLAG_W-1:0] s_flags_r;
  logic [FLAG_W-1:0] s_flags_nxt;
  logic [15:0] sts_r;
  logic [15:0] sts_nxt;
  logic refresh;
  always_comb begin
    // Snapshot taken only on a good enabled call
    refresh = go && !(counter_command == CMD_LOAD && cfg_bad);
    s_acc_nxt = s_acc_r;
    s_flags_nxt = s_flags_r;
    if (do_preset) begin
      s_acc_nxt = preload_count_value;
      s_flags_nxt = FLAGS_CLEAR;
    end else if (refresh) begin
      s_acc_nxt = acc_r;
      s_flags_nxt = flags_r;
    end
    if (!cmd_enable) begin
      sts_nxt = STS_DISABLED;
    end else if (!id_ok) begin
      sts_nxt = STS_BAD_ID;
    end else if (!cmd_known) begin
      sts_nxt = STS_BAD_CMD;
    end else if (counter_command == CMD_LOAD && cfg_bad) begin
      sts_nxt = STS_CFG_ERR;
    end else begin
      sts_nxt = STS_OK;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_acc_r <= WORD_RESET;
      s_flags_r <= FLAGS_CLEAR;
      sts_r <= STS_DISABLED;
    end else begin
      s_acc_r <= s_acc_nxt;
      s_flags_r <= s_flags_nxt;
      sts_r <= sts_nxt;
    end
  end

  assign exec_sts = sts_r;
  assign counting = run_r;
  assign cfg_acc_mirror = acc_r;
  assign status_acc = s_acc_r;
  assign status_flags = s_flags_r;
  assign status_upper = hw_upper;
  assign status_lower = hw_lower;
  assign status_upper_out = hw_upper_out;
  assign status_lower_out = hw_lower_out;

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence load_call;
    cmd_enable && id_ok && counter_command == CMD_LOAD && !cfg_bad;
  endsequence
  sequence preset_call;
    cmd_enable && id_ok && counter_command == CMD_PRESET;
  endsequence
  a_off_no_refresh: assert property (
    !cmd_enable |=> $stable(s_acc_r) && $stable(s_flags_r)
  ) else $error("Status info changed while disabled");
  a_run_starts: assert property (
    cmd_enable && id_ok && counter_command == CMD_RUN && !counting
    |=> counting && status_acc == $past(acc_r)
  ) else $error("Run command did not start the counter");
  a_stop_halts: assert property (
    cmd_enable && id_ok && counter_command == CMD_STOP |=> !counting
  ) else $error("Stop command did not halt the counter");
  a_run_holds: assert property (
    counting && !(cmd_enable && id_ok && counter_command == CMD_STOP)
    |=> counting
  ) else $error("Counter stopped without stop command");
  a_load_words: assert property (
    load_call |=> status_upper == $past(upper_setpoint_cfg) &&
    hw_under == $past(underflow_limit) && counting == $past(counting)
  ) else $error("Load did not copy configuration");
  a_load_repeat: assert property (
    load_call ##1 load_call
    |=> hw_over == $past(overflow_limit) && exec_sts == STS_OK
  ) else $error("Held load did not reload");
  a_preset_acc: assert property (
    preset_call |=> cfg_acc_mirror == $past(preload_count_value) &&
    status_flags == FLAGS_CLEAR && counting == $past(counting)
  ) else $error("Preset did not set accumulator");
  a_sts_off: assert property (
    !cmd_enable |=> exec_sts == STS_DISABLED
  ) else $error("Disabled call gave nonzero status");
  a_cfg_error: assert property (
    cmd_enable && id_ok && counter_command == CMD_LOAD &&
    upper_setpoint_cfg > overflow_limit
    |=> exec_sts == STS_CFG_ERR && $stable(hw_upper)
  ) else $error("Bad setpoint accepted");
  a_bad_cmd: assert property (
    cmd_enable && id_ok && !cmd_known
    |=> exec_sts == STS_BAD_CMD && $stable(run_r) && $stable(hw_upper)
  ) else $error("Invalid command not rejected");
  a_override_flags: assert property (
    set_enable && set_counter_id == OWN_COUNTER_ID && !cmd_enable
    ##1 !cmd_enable && !step
    |=> flags_r[F_OVER] == $past(overflow_seen, 2)
  ) else $error("Override did not write flags");
  a_override_sts: assert property (
    set_sts != STS_BAD_CMD && set_sts != STS_CFG_ERR
  ) else $error("Override reported a forbidden code");
endmodule // pulse_counter_command_unit
`default_nettype wire

// ==== dv/pulse_counter_command_unit_tb.sv ====
// Self-checking bench for the pulse counter command unit.
// Assumes the command package is compiled first; bench drives every port.
`timescale 1ns/1ps
`default_nettype none
module pulse_counter_command_unit_tb
  import pulse_cmd_pkg::*;
;
  // ***************************************************
  // Stimulus and observed signals
  // ***************************************************
  logic sys_clk, nrst, cmd_enable, count_pulse, count_down, set_enable;
  logic [7:0] counter_id, counter_command, set_counter_id;
  logic signed [31:0] upper_setpoint_cfg, lower_setpoint_cfg;
  logic signed [31:0] overflow_limit, underflow_limit;
  logic [31:0] upper_output_pattern, lower_output_pattern;
  logic [31:0] preload_count_value;
  logic single_run_done, upper_setpoint_hit, lower_setpoint_hit;
  logic overflow_seen, underflow_seen, counting;
  logic [15:0] exec_sts, set_sts;
  logic [31:0] cfg_acc_mirror, status_acc, status_upper, status_lower;
  logic [31:0] status_upper_out, status_lower_out;
  logic [FLAG_W-1:0] status_flags;
  int checks = 0;
  int mismatches = 0;
  logic [7:0] bad_cmds [3] = '{8'h00, 8'h05, 8'hff};

  pulse_counter_command_unit i_pulse_counter_command_unit (
    .sys_clk(sys_clk), .nrst(nrst), .cmd_enable(cmd_enable),
    .counter_id(counter_id), .counter_command(counter_command),
    .upper_setpoint_cfg(upper_setpoint_cfg),
    .lower_setpoint_cfg(lower_setpoint_cfg),
    .upper_output_pattern(upper_output_pattern),
    .lower_output_pattern(lower_output_pattern),
    .overflow_limit(overflow_limit), .underflow_limit(underflow_limit),
    .preload_count_value(preload_count_value),
    .count_pulse(count_pulse), .count_down(count_down),
    .set_enable(set_enable), .set_counter_id(set_counter_id),
    .single_run_done(single_run_done),
    .upper_setpoint_hit(upper_setpoint_hit),
    .lower_setpoint_hit(lower_setpoint_hit),
    .overflow_seen(overflow_seen), .underflow_seen(underflow_seen),
    .exec_sts(exec_sts), .set_sts(set_sts), .counting(counting),
    .cfg_acc_mirror(cfg_acc_mirror), .status_acc(status_acc),
    .status_upper(status_upper), .status_lower(status_lower),
    .status_upper_out(status_upper_out),
    .status_lower_out(status_lower_out), .status_flags(status_flags)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ***************************************************
  // Access and compare tasks
  // ***************************************************
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sts_is(input logic [15:0] exp);
    chk({16'h0000, exec_sts}, {16'h0000, exp});
  endtask

  task automatic run_is(input logic exp);
    chk({31'h0, counting}, {31'h0, exp});
  endtask

  // One execution: enable for a single clock, sample after it lands
  task automatic call(input logic [7:0] cmd, input logic [7:0] id);
    @(posedge sys_clk);
    cmd_enable <= 1'b1;
    counter_command <= cmd;
    counter_id <= id;
    @(posedge sys_clk);
    cmd_enable <= 1'b0;
    #1;
  endtask

  task automatic ovr(input logic en, input logic [7:0] id,
                     input logic [4:0] f);
    @(posedge sys_clk);
    set_enable <= en;
    set_counter_id <= id;
    {underflow_seen, overflow_seen, lower_setpoint_hit,
     upper_setpoint_hit, single_run_done} <= f;
    @(posedge sys_clk);
    set_enable <= 1'b0;
    #1;
  endtask

  // Pulses last two clocks so the synchroniser cannot miss them
  task automatic pulses(input int n, input logic dn);
    @(posedge sys_clk);
    count_down <= dn;
    repeat (3) @(posedge sys_clk);
    repeat (n) begin
      count_pulse <= 1'b1;
      repeat (2) @(posedge sys_clk);
      count_pulse <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask

  task automatic wait_acc(input logic [31:0] exp);
    int n;
    n = 0;
    #1;
    while (cfg_acc_mirror !== exp && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(cfg_acc_mirror, exp);
    if (cfg_acc_mirror !== exp) begin
      print_verdict();
    end
  endtask

  task automatic refresh_flags(input logic [4:0] exp);
    repeat (2) @(posedge sys_clk);
    call(8'h03, 8'h00);
    chk({27'h0, status_flags}, {27'h0, exp});
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    nrst = 1'b0;
    {cmd_enable, count_pulse, count_down, set_enable} = 4'h0;
    {counter_id, counter_command, set_counter_id} = 24'h000000;
    {single_run_done, upper_setpoint_hit, lower_setpoint_hit} = 3'h0;
    {overflow_seen, underflow_seen} = 2'h0;
    upper_setpoint_cfg = 32'h64;
    lower_setpoint_cfg = 32'hffffff9c;
    upper_output_pattern = 32'h0f;
    lower_output_pattern = 32'hf0;
    overflow_limit = 32'h3e8;
    underflow_limit = 32'hfffffc18;
    preload_count_value = 32'h0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    sts_is(STS_DISABLED);
    run_is(1'b0);
    call(8'h03, 8'h00);
    sts_is(STS_OK);
    chk(status_upper, 32'h64);
    chk(status_lower, 32'hffffff9c);
    chk(status_upper_out, 32'h0f);
    chk(status_lower_out, 32'hf0);
    // Held load: second execution picks up the changed setpoint
    @(posedge sys_clk);
    cmd_enable <= 1'b1;
    @(posedge sys_clk);
    upper_setpoint_cfg <= 32'hc8;
    #1;
    chk(status_upper, 32'h64);
    @(posedge sys_clk);
    cmd_enable <= 1'b0;
    upper_setpoint_cfg <= 32'h7d0;
    #1;
    chk(status_upper, 32'hc8);
    call(8'h03, 8'h00);
    sts_is(STS_CFG_ERR);
    chk(status_upper, 32'hc8);
    upper_setpoint_cfg <= 32'h64;
    lower_setpoint_cfg <= 32'hfffff830;
    call(8'h03, 8'h00);
    sts_is(STS_CFG_ERR);
    chk(status_lower, 32'hffffff9c);
    lower_setpoint_cfg <= 32'hffffff9c;
    foreach (bad_cmds[i]) begin
      call(bad_cmds[i], 8'h00);
      sts_is(STS_BAD_CMD);
      run_is(1'b0);
    end
    call(8'h01, 8'h01);
    sts_is(STS_BAD_ID);
    run_is(1'b0);
    @(posedge sys_clk);
    counter_command <= 8'h01;
    repeat (2) @(posedge sys_clk);
    #1;
    run_is(1'b0);
    sts_is(STS_DISABLED);
    call(8'h01, 8'h00);
    run_is(1'b1);
    pulses(3, 1'b0);
    wait_acc(32'h3);
    call(8'h01, 8'h00);
    chk(status_acc, 32'h3);
    pulses(2, 1'b0);
    wait_acc(32'h5);
    chk(status_acc, 32'h3);
    run_is(1'b1);
    lower_output_pattern <= 32'ha5;
    call(8'h03, 8'h00);
    chk(status_lower_out, 32'ha5);
    chk(cfg_acc_mirror, 32'h5);
    run_is(1'b1);
    preload_count_value <= 32'h32;
    call(8'h04, 8'h00);
    chk(cfg_acc_mirror, 32'h32);
    chk(status_acc, 32'h32);
    chk({27'h0, status_flags}, 32'h0);
    run_is(1'b1);
    pulses(2, 1'b1);
    wait_acc(32'h30);
    call(8'h02, 8'h00);
    run_is(1'b0);
    sts_is(STS_OK);
    // Flag overrides only while stopped
    ovr(1'b1, 8'h00, 5'h1d);
    chk({16'h0, set_sts}, {16'h0, STS_OK});
    refresh_flags(5'h1d);
    ovr(1'b1, 8'h00, 5'h06);
    refresh_flags(5'h06);
    ovr(1'b0, 8'h00, 5'h1f);
    chk({16'h0, set_sts}, {16'h0, STS_DISABLED});
    refresh_flags(5'h06);
    ovr(1'b1, 8'h02, 5'h1f);
    chk({16'h0, set_sts}, {16'h0, STS_BAD_ID});
    refresh_flags(5'h06);
    print_verdict();
  end
endmodule // pulse_counter_command_unit_tb
`default_nettype wire
